/* File: shared/atm_pkg.sv */
// Shared constants, types and helpers of the aux temperature monitor.
// Assumes a 100 MHz system clock; offsets are byte addresses of 16-bit registers.
`default_nettype none
package atm_pkg;
	localparam int SYS_MHZ = 100;
	localparam int INT_MHZ = 8;
	localparam logic [6:0] ACC_STEP = 7'(INT_MHZ);
	localparam logic [6:0] ACC_WRAP = 7'(SYS_MHZ - INT_MHZ);
	localparam int MS_NS = 1_000_000;
	localparam int PULSE_NS = 2_000_000;
	localparam int MS_CYC = MS_NS * SYS_MHZ / 1000;
	localparam int PULSE_CYC = PULSE_NS * SYS_MHZ / 1000;
	localparam logic [3:0] SAMPLE_INT_CYC = 4'h3;
	localparam logic [15:0] RATIO_LO = 16'h000d;
	localparam logic [15:0] RATIO_HI = 16'h0011;
	// Register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_IVAL = 8'h08;
	localparam logic [7:0] OFS_TMIN = 8'h0c;
	localparam logic [7:0] OFS_TMAX = 8'h10;
	localparam logic [7:0] OFS_TLOW = 8'h14;
	localparam logic [7:0] OFS_THIGH = 8'h18;
	localparam logic [7:0] OFS_ISTAT = 8'h1c;
	localparam logic [7:0] OFS_IMASK = 8'h20;
	localparam logic [7:0] OFS_KMUL = 8'h24;
	localparam logic [7:0] OFS_RATIO = 8'h28;
	// Control fields
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_RES_LSB = 2;
	localparam int CTRL_DIFF = 4;
	localparam int CTRL_START = 5;
	localparam int CTRL_AUTO = 6;
	localparam int CTRL_IRQEN = 7;
	localparam int CTRL_RATIO = 8;
	localparam int CTRL_PLL = 9;
	localparam logic [15:0] CTRL_WMASK = 16'h03df;
	// Status and interrupt fields
	localparam int ST_BUSY = 0;
	localparam int ST_OOR = 1;
	localparam int ST_OSC = 2;
	localparam int ST_AUDIO = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_OOR = 1;
	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] IVAL_RST = 16'h0064;
	localparam logic [11:0] TMIN_RST = 12'h000;
	localparam logic [11:0] TMAX_RST = 12'hfff;
	localparam logic [7:0] KMUL_RST = 8'h01;
	localparam logic [1:0] IMASK_RST = 2'h0;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_LOW = 2'b01,
		S_HIGH = 2'b10
	} atm_state_e;

	typedef enum logic [1:0] {
		SAR_IDLE = 2'b00,
		SAR_SAMP = 2'b01,
		SAR_CONV = 2'b10
	} atm_sar_e;

	function automatic logic [3:0] atm_nbits(input logic [1:0] res);
		atm_nbits = (res == 2'd0) ? 4'd8 : (res == 2'd1) ? 4'd10 : 4'd12;
	endfunction

	function automatic logic atm_outside(input logic [11:0] v, input logic [11:0] mn,
		input logic [11:0] mx);
		atm_outside = (v < mn) || (v > mx);
	endfunction
endpackage
`default_nettype wire

/* File: core/atm_clkdiv.sv */
// Internal 8 MHz tick from the system clock and the divided converter tick.
// Assumes a 100 MHz sys_clk; ticks are one-cycle enables, not clocks.
`timescale 1ns/1ns
`default_nettype none
module atm_clkdiv
	import atm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Divider select: 0 /1, 1 /2, 2 /4, 3 /8
	input wire logic [1:0] div_sel,
	// Ticks
	output logic int_tick_r,
	output logic conv_tick_r
);
	logic [6:0] acc_r;
	logic [2:0] dcnt_r;
	logic wrap;
	logic [2:0] lim;

	assign wrap = acc_r >= ACC_WRAP;
	assign lim = 3'((4'd1 << div_sel) - 4'd1);

	// Fractional accumulator keeps 8 MHz on average whatever the divider
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 7'd0;
			int_tick_r <= 1'b0;
		end else begin
			acc_r <= wrap ? acc_r - ACC_WRAP : acc_r + ACC_STEP;
			int_tick_r <= wrap;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dcnt_r <= 3'd0;
			conv_tick_r <= 1'b0;
		end else begin
			conv_tick_r <= 1'b0;
			if (wrap) begin
				if (dcnt_r >= lim) begin
					dcnt_r <= 3'd0;
					conv_tick_r <= 1'b1;
				end else begin
					dcnt_r <= dcnt_r + 3'd1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: core/atm_sar.sv */
// Successive approximation sequencer: sampling phase then one bit per converter tick.
// Assumes cmp_hi is already synchronised and settles within one internal tick.
`timescale 1ns/1ns
`default_nettype none
module atm_sar
	import atm_pkg::*;
#(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Control
	input wire logic start,
	input wire logic int_tick,
	input wire logic conv_tick,
	input wire logic [3:0] nbits,
	// Comparator: input above trial level
	input wire logic cmp_hi,
	// Results
	output logic busy_r,
	output logic done_r,
	output logic sample_r,
	output logic [W-1:0] trial_r,
	output logic [W-1:0] result_r
);
	atm_sar_e state_r;
	logic [3:0] scnt_r;
	logic [3:0] bit_r;
	logic [W-1:0] kept;

	assign kept = cmp_hi ? trial_r : trial_r & ~(W'(1) << bit_r);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= SAR_IDLE;
			scnt_r <= 4'd0;
			bit_r <= 4'd0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			sample_r <= 1'b0;
			trial_r <= '0;
			result_r <= '0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				SAR_IDLE: begin
					if (start) begin
						state_r <= SAR_SAMP;
						scnt_r <= 4'd0;
						sample_r <= 1'b1;
						busy_r <= 1'b1;
					end
				end
				SAR_SAMP: begin
					if (scnt_r != SAMPLE_INT_CYC) begin
						if (int_tick) begin
							scnt_r <= scnt_r + 4'd1;
						end
					end else if (conv_tick) begin
						state_r <= SAR_CONV;
						sample_r <= 1'b0;
						bit_r <= nbits - 4'd1;
						trial_r <= W'(1) << (nbits - 4'd1);
					end
				end
				SAR_CONV: begin
					if (conv_tick) begin
						if (bit_r == 4'd0) begin
							result_r <= kept;
							done_r <= 1'b1;
							busy_r <= 1'b0;
							trial_r <= '0;
							state_r <= SAR_IDLE;
						end else begin
							trial_r <= kept | (W'(1) << (bit_r - 4'd1));
							bit_r <= bit_r - 4'd1;
						end
					end
				end
				default: begin
					state_r <= SAR_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: core/atm_top.sv */
// Aux measurement clocking and temperature monitor with threshold check.
// Assumes one 100 MHz clock; audio power levels come from same-clock logic.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Internal 8 MHz tick, divided for converter
// - Internal tick rate ignores divider setting
// - Sampling phase of fixed internal cycles (3 internal ticks, then held until the next converter tick)
// - Audio converters off: use internal oscillator
// - Audio converter on: oscillator off, audio clocks
// - Ratio bit picks 13 or 17, K
// - Single mode: one low-current conversion
// - Differential: low then 82x current conversion
// - Auto mode starts conversion each interval
// - Programmable minimum and maximum thresholds
// - Out-of-range flag, cleared by reading
// - Enabled: 2 ms high pulse on pin
// - Resolutions of 8, 10, 12 bits
// - Unsigned results readable by host
module atm_top
	import atm_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYC,
	parameter int PULSE_CYCLES = PULSE_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Audio converter power levels
	input wire logic adc_pwr,
	input wire logic dac_pwr,
	// Analog front end
	input wire logic cmp_hi_pin,
	output logic sample_en,
	output logic bias_high,
	output logic [11:0] sar_code,
	// Clock source
	output logic osc_en,
	output logic audio_clk_src,
	// Events
	output logic general_pin_one,
	output logic irq
);
	atm_state_e state_r;
	logic [15:0] ctrl_r;
	logic [15:0] ival_r;
	logic [11:0] tmin_r;
	logic [11:0] tmax_r;
	logic [7:0] kmul_r;
	logic [11:0] temp_low_current_reading;
	logic [11:0] temp_high_current_reading;
	logic [1:0] istat_r;
	logic [1:0] imask_r;
	logic oor_r;
	logic cmp_m_r;
	logic cmp_s_r;
	logic sar_start_r;
	logic auto_run_r;
	logic auto_pend_r;
	logic done_ev_r;
	logic oor_ev_r;
	logic [16:0] ms_cnt_r;
	logic ms_tick_r;
	logic [15:0] ival_cnt_r;
	logic [17:0] pcnt_r;
	logic [15:0] rd_mux;
	logic [15:0] ratio_mult;
	logic int_tick;
	logic conv_tick;
	logic sar_busy;
	logic sar_done;
	logic [11:0] sar_result;
	logic busy;
	logic sw_go;
	logic go;
	logic expire;
	logic rd_stat;
	logic rd_istat;
	logic pulse_load;
	logic [1:0] istat_set;

	assign busy = state_r != S_IDLE;
	assign sw_go = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_START];
	assign go = !busy && (sw_go || auto_pend_r);
	assign rd_stat = reg_rd && reg_addr == OFS_STAT;
	assign rd_istat = reg_rd && reg_addr == OFS_ISTAT;
	assign pulse_load = oor_ev_r && ctrl_r[CTRL_IRQEN];
	assign istat_set = {oor_ev_r, done_ev_r};
	assign expire = ctrl_r[CTRL_AUTO] && ms_tick_r
		&& (17'(ival_cnt_r) + 17'd1) >= {1'b0, ival_r};

	atm_clkdiv u_clkdiv (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.div_sel(ctrl_r[CTRL_DIV_LSB +: 2]),
		.int_tick_r(int_tick),
		.conv_tick_r(conv_tick)
	);

	atm_sar #(
		.W(12)
	) u_sar (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.start(sar_start_r),
		.int_tick(int_tick),
		.conv_tick(conv_tick),
		.nbits(atm_nbits(ctrl_r[CTRL_RES_LSB +: 2])),
		.cmp_hi(cmp_s_r),
		.busy_r(sar_busy),
		.done_r(sar_done),
		.sample_r(sample_en),
		.trial_r(sar_code),
		.result_r(sar_result)
	);

	// Comparator pin synchroniser
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmp_m_r <= 1'b0;
			cmp_s_r <= 1'b0;
		end else begin
			cmp_m_r <= cmp_hi_pin;
			cmp_s_r <= cmp_m_r;
		end
	end

	// Oscillator runs only while both audio converters are down
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			osc_en <= 1'b1;
			audio_clk_src <= 1'b0;
		end else begin
			osc_en <= !(adc_pwr || dac_pwr);
			audio_clk_src <= adc_pwr || dac_pwr;
		end
	end

	// Register writes
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= CTRL_RST;
			ival_r <= IVAL_RST;
			tmin_r <= TMIN_RST;
			tmax_r <= TMAX_RST;
			kmul_r <= KMUL_RST;
			imask_r <= IMASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: ctrl_r <= reg_wdata & CTRL_WMASK;
				OFS_IVAL: ival_r <= reg_wdata;
				OFS_TMIN: tmin_r <= reg_wdata[11:0];
				OFS_TMAX: tmax_r <= reg_wdata[11:0];
				OFS_KMUL: kmul_r <= reg_wdata[7:0];
				OFS_IMASK: imask_r <= reg_wdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// Derived audio clock multiplier, with or without the loop
	assign ratio_mult = 16'({8'h00, ctrl_r[CTRL_PLL] ? kmul_r : 8'h01}
		* (ctrl_r[CTRL_RATIO] ? RATIO_HI : RATIO_LO));

	// Read mux
	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr)
			OFS_CTRL: rd_mux = ctrl_r;
			OFS_STAT: begin
				rd_mux[ST_BUSY] = busy;
				rd_mux[ST_OOR] = oor_r;
				rd_mux[ST_OSC] = osc_en;
				rd_mux[ST_AUDIO] = audio_clk_src;
			end
			OFS_IVAL: rd_mux = ival_r;
			OFS_TMIN: rd_mux = {4'h0, tmin_r};
			OFS_TMAX: rd_mux = {4'h0, tmax_r};
			OFS_TLOW: rd_mux = {4'h0, temp_low_current_reading};
			OFS_THIGH: rd_mux = {4'h0, temp_high_current_reading};
			OFS_ISTAT: rd_mux = {14'h0000, istat_r};
			OFS_IMASK: rd_mux = {14'h0000, imask_r};
			OFS_KMUL: rd_mux = {8'h00, kmul_r};
			OFS_RATIO: rd_mux = ratio_mult;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

	// Millisecond base and auto interval
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ms_cnt_r <= 17'd0;
			ms_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= ms_cnt_r == 17'(MS_CYCLES - 1);
			ms_cnt_r <= (ms_cnt_r == 17'(MS_CYCLES - 1)) ? 17'd0 : ms_cnt_r + 17'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ival_cnt_r <= 16'h0000;
			auto_pend_r <= 1'b0;
		end else begin
			if (!ctrl_r[CTRL_AUTO] || expire) begin
				ival_cnt_r <= 16'h0000;
			end else if (ms_tick_r) begin
				ival_cnt_r <= ival_cnt_r + 16'h0001;
			end
			// A new expiry wins over the start that takes the old one
			auto_pend_r <= expire || (auto_pend_r && busy && ctrl_r[CTRL_AUTO]);
		end
	end

	// Temperature sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= S_IDLE;
			sar_start_r <= 1'b0;
			bias_high <= 1'b0;
			auto_run_r <= 1'b0;
			done_ev_r <= 1'b0;
			oor_ev_r <= 1'b0;
			temp_low_current_reading <= 12'h000;
			temp_high_current_reading <= 12'h000;
		end else begin
			sar_start_r <= 1'b0;
			done_ev_r <= 1'b0;
			oor_ev_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (go) begin
						state_r <= S_LOW;
						sar_start_r <= 1'b1;
						bias_high <= 1'b0;
						auto_run_r <= auto_pend_r;
					end
				end
				S_LOW: begin
					if (sar_done) begin
						temp_low_current_reading <= sar_result;
						if (ctrl_r[CTRL_DIFF]) begin
							state_r <= S_HIGH;
							sar_start_r <= 1'b1;
							bias_high <= 1'b1;
						end else begin
							state_r <= S_IDLE;
							done_ev_r <= 1'b1;
							oor_ev_r <= auto_run_r
								&& atm_outside(sar_result, tmin_r, tmax_r);
						end
					end
				end
				S_HIGH: begin
					if (sar_done) begin
						temp_high_current_reading <= sar_result;
						state_r <= S_IDLE;
						bias_high <= 1'b0;
						done_ev_r <= 1'b1;
						oor_ev_r <= auto_run_r
							&& atm_outside(temp_low_current_reading, tmin_r, tmax_r);
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Sticky flags: a set in the clearing read's cycle survives
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			oor_r <= 1'b0;
			istat_r <= 2'h0;
			irq <= 1'b0;
		end else begin
			oor_r <= oor_ev_r || (oor_r && !rd_stat);
			istat_r <= istat_set | (istat_r & {2{!rd_istat}});
			irq <= |(istat_r & imask_r);
		end
	end

	// Threshold pulse on the general pin, retriggerable
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pcnt_r <= 18'd0;
			general_pin_one <= 1'b0;
		end else if (pulse_load) begin
			pcnt_r <= 18'(PULSE_CYCLES);
			general_pin_one <= 1'b1;
		end else if (pcnt_r != 18'd0) begin
			pcnt_r <= pcnt_r - 18'd1;
			general_pin_one <= pcnt_r != 18'd1;
		end
	end

	// Checks
	logic [17:0] plen_q;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			plen_q <= 18'd0;
		end else if (pulse_load) begin
			plen_q <= 18'd0;
		end else if (general_pin_one) begin
			plen_q <= plen_q + 18'd1;
		end else begin
			plen_q <= 18'd0;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	property p_tick_rate;
		int_tick |=> !int_tick [*8];
	endproperty
	a_tick_rate: assert property (p_tick_rate) else $error("internal tick too fast");

	property p_conv_on_tick;
		conv_tick |-> int_tick;
	endproperty
	a_conv_on_tick: assert property (p_conv_on_tick) else $error("converter tick off grid");

	property p_sample;
		$rose(sample_en) |-> sample_en [*8];
	endproperty
	a_sample: assert property (p_sample) else $error("sampling phase too short");

	property p_osc;
		!(adc_pwr || dac_pwr) |=> osc_en && !audio_clk_src;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator not selected");

	property p_audio;
		(adc_pwr || dac_pwr) |=> !osc_en && audio_clk_src;
	endproperty
	a_audio: assert property (p_audio) else $error("audio clocks not selected");

	property p_single;
		state_r == S_LOW && sar_done && !ctrl_r[CTRL_DIFF] |=> state_r == S_IDLE && done_ev_r;
	endproperty
	a_single: assert property (p_single) else $error("single reading did not finish");

	property p_diff;
		state_r == S_LOW && sar_done && ctrl_r[CTRL_DIFF] |=> bias_high ##2 sar_busy;
	endproperty
	a_diff: assert property (p_diff) else $error("second reading not started");

	property p_auto;
		auto_pend_r && !busy |=> state_r == S_LOW ##1 sar_busy;
	endproperty
	a_auto: assert property (p_auto) else $error("auto start missed");

	property p_oor_set;
		oor_ev_r |=> oor_r ##1 (oor_r || $past(rd_stat));
	endproperty
	a_oor_set: assert property (p_oor_set) else $error("range flag not held");

	property p_oor_clr;
		rd_stat && !oor_ev_r |=> !oor_r;
	endproperty
	a_oor_clr: assert property (p_oor_clr) else $error("range flag not cleared");

	property p_below;
		state_r == S_LOW && sar_done && auto_run_r && !ctrl_r[CTRL_DIFF]
			&& sar_result < tmin_r |=> ##1 oor_r;
	endproperty
	a_below: assert property (p_below) else $error("low result not flagged");

	property p_pulse_len;
		$fell(general_pin_one) |-> plen_q == 18'(PULSE_CYCLES);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pin pulse length wrong");

	property p_pulse_cause;
		$rose(general_pin_one) |-> $past(oor_ev_r) && $past(ctrl_r[CTRL_IRQEN]);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("pin pulse without cause");

	property p_res;
		sar_done |-> (sar_result >> atm_nbits(ctrl_r[CTRL_RES_LSB +: 2])) == 12'h000;
	endproperty
	a_res: assert property (p_res) else $error("result wider than resolution");

	property p_read_low;
		reg_rd && reg_addr == OFS_TLOW |=> reg_rdata == {4'h0, $past(temp_low_current_reading)};
	endproperty
	a_read_low: assert property (p_read_low) else $error("low reading readback wrong");

	c_diff: cover property (state_r == S_HIGH && sar_done);
	c_pulse: cover property ($fell(general_pin_one));
	c_auto: cover property (auto_pend_r && !busy);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* File: bench/atm_diode_model.sv */
// Model of the diode sensor and comparator facing the converter.
// Assumes the bench sets each diode level as a whole code.
`timescale 1ns/1ns
`default_nettype none
module atm_diode_model (
	// Front end from the converter
	input wire logic bias_high,
	input wire logic [11:0] sar_code,
	// Diode levels seen at low and high bias, in codes
	input wire logic [11:0] lvl_low,
	input wire logic [11:0] lvl_high,
	// Comparator
	output logic cmp_hi_pin
);
	// The level sits half a code above its whole code, so no trial ever ties with it
	assign cmp_hi_pin = sar_code <= (bias_high ? lvl_high : lvl_low);
endmodule
`default_nettype wire

/* File: bench/atm_top_tb.sv */
// Self-checking bench of the temperature monitor with a diode model.
// Assumes short ms and pulse counts set through the top's parameters.
`timescale 1ns/1ns
`default_nettype none
module atm_top_tb;
	import atm_pkg::*;
	localparam int MS_T = 50;
	localparam int PULSE_T = 40;
	logic sys_clk, resetn, reg_wr, reg_rd, adc_pwr, dac_pwr, cmp_hi_pin;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic sample_en, bias_high, osc_en, audio_clk_src, general_pin_one, irq, samp_q, pin_q;
	logic [11:0] sar_code, lvl_low, lvl_high;
	int n_mismatch, n_compared, samp_cyc, samp_rise, pin_len, last_pulse, i;

	atm_top #(.MS_CYCLES(MS_T), .PULSE_CYCLES(PULSE_T)) u_atm_top (
		.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_pwr(adc_pwr),
		.dac_pwr(dac_pwr), .cmp_hi_pin(cmp_hi_pin), .sample_en(sample_en),
		.bias_high(bias_high), .sar_code(sar_code), .osc_en(osc_en),
		.audio_clk_src(audio_clk_src), .general_pin_one(general_pin_one), .irq(irq));
	atm_diode_model u_atm_diode_model (.bias_high(bias_high), .sar_code(sar_code),
		.lvl_low(lvl_low), .lvl_high(lvl_high), .cmp_hi_pin(cmp_hi_pin));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Counts sampling cycles and phases, and the length of each pin pulse
	always @(posedge sys_clk) begin
		samp_q <= sample_en;
		pin_q <= general_pin_one;
		if (sample_en === 1'b1)
			samp_cyc <= samp_cyc + 1;
		if (sample_en === 1'b1 && samp_q !== 1'b1)
			samp_rise <= samp_rise + 1;
		if (general_pin_one === 1'b1)
			pin_len <= pin_len + 1;
		else if (pin_q === 1'b1)
			last_pulse <= pin_len;
		else
			pin_len <= 0;
	end

	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi) begin
			n_mismatch++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp, input string what);
		logic [15:0] v;
		rd(a, v);
		chk(what, exp, v);
	endtask

	function automatic logic [15:0] exp_ratio(input logic [7:0] k, input logic pll,
		input logic sel);
		return 16'((pll ? k : 8'h01) * (sel ? RATIO_HI : RATIO_LO));
	endfunction

	// One manual conversion, with a second start that lands while busy
	task automatic conv(input logic [1:0] res, input logic diff);
		logic [1:0] dv;
		logic [15:0] s, cv;
		int nb, nc, dur;
		time t0;
		nb = (res == 2'd3) ? 12 : 8 + 2 * int'(res);
		nc = diff ? 2 : 1;
		dv = (res == 2'd0) ? 2'd0 : (res == 2'd1) ? 2'd1 : 2'd2 + 2'($urandom % 2);
		lvl_low <= 12'($urandom % (1 << nb));
		lvl_high <= 12'($urandom % (1 << nb));
		samp_cyc = 0;
		samp_rise = 0;
		cv = {11'h0, diff, res, dv} | (16'h0001 << CTRL_START);
		t0 = $time;
		wr(OFS_CTRL, cv);
		wr(OFS_CTRL, cv);
		dur = 0;
		do begin
			rd(OFS_STAT, s);
			dur = int'(($time - t0) / 10);
		end while (s[ST_BUSY] === 1'b1 && dur < 6000);
		chk_rng("busy cycles", nc * (36 + (nb - 1) * (12 << dv)),
			nc * (60 + (nb + 1) * (13 << dv)), dur);
		chk_rng("sampling cycles", 36 * nc, nc * (41 + (13 << dv)), samp_cyc);
		chk("sampling phases", 16'(nc), 16'(samp_rise));
		rdchk(OFS_TLOW, {4'h0, lvl_low}, "low reading");
		if (diff)
			rdchk(OFS_THIGH, {4'h0, lvl_high}, "high reading");
		chk("irq on done", 16'h0001, 16'(irq));
		rdchk(OFS_ISTAT, 16'h0001, "istat done");
		rdchk(OFS_ISTAT, 16'h0000, "istat cleared");
		chk("irq after clear", 16'h0000, 16'(irq));
	endtask

	// One automatic run checked against the thresholds
	task automatic auto_run(input logic [11:0] v, input logic [11:0] mn, input logic [11:0] mx,
		input logic ien, input logic [1:0] msk);
		logic [15:0] s, fl;
		logic oor;
		int n;
		oor = (v < mn) || (v > mx);
		lvl_low <= v;
		last_pulse = 0;
		fl = 16'h0000;
		wr(OFS_TMIN, {4'h0, mn});
		wr(OFS_TMAX, {4'h0, mx});
		wr(OFS_IMASK, {14'h0, msk});
		wr(OFS_IVAL, 16'h0008);
		wr(OFS_CTRL, 16'(ien) << CTRL_IRQEN | 16'h0001 << CTRL_AUTO);
		for (n = 0; n < 900 && sample_en !== 1'b1; n++)
			@(posedge sys_clk);
		chk_rng("auto start delay", 4 * MS_T, 8 * MS_T + 20, n);
		n = 0;
		do begin
			rd(OFS_STAT, s);
			fl = fl | s;
			n++;
		end while (s[ST_BUSY] === 1'b1 && n < 200);
		rd(OFS_STAT, s);
		fl = fl | s;
		chk("range flag", 16'(oor), 16'(fl[ST_OOR]));
		rd(OFS_STAT, s);
		chk("flag after read", 16'h0000, 16'(s[ST_OOR]));
		chk("irq level", 16'(msk[0] | (msk[1] & oor)), 16'(irq));
		rdchk(OFS_ISTAT, {14'h0, oor, 1'b1}, "istat auto");
		repeat (2) @(posedge sys_clk);
		chk("irq after clear", 16'h0000, 16'(irq));
		for (n = 0; n < 100 && general_pin_one !== 1'b0; n++)
			@(posedge sys_clk);
		chk("pin idle", 16'h0000, 16'(general_pin_one));
		repeat (2) @(posedge sys_clk);
		chk("pin pulse cycles", (oor && ien) ? 16'(PULSE_T) : 16'h0000, 16'(last_pulse));
		wr(OFS_CTRL, 16'h0000);
	endtask

	initial begin
		#500_000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		resetn = 1'b0;
		{reg_wr, reg_rd, adc_pwr, dac_pwr} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		{lvl_low, lvl_high} = 24'h0;
		{samp_q, pin_q} = 2'b00;
		{n_mismatch, n_compared, samp_cyc, samp_rise, pin_len, last_pulse} = '0;
		void'($urandom(30011));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rdchk(OFS_CTRL, CTRL_RST, "ctrl reset");
		rdchk(OFS_STAT, 16'h0004, "stat reset");
		rdchk(OFS_IVAL, IVAL_RST, "ival reset");
		rdchk(OFS_TMIN, {4'h0, TMIN_RST}, "tmin reset");
		rdchk(OFS_TMAX, {4'h0, TMAX_RST}, "tmax reset");
		rdchk(OFS_KMUL, {8'h00, KMUL_RST}, "kmul reset");
		rdchk(OFS_IMASK, {14'h0, IMASK_RST}, "imask reset");
		rdchk(OFS_RATIO, RATIO_LO, "ratio reset");
		wr(8'h2c, 16'hffff);
		rdchk(8'h2c, 16'h0000, "unmapped");
		wr(OFS_TLOW, 16'hffff);
		rdchk(OFS_TLOW, 16'h0000, "read-only low reading");
		for (i = 0; i < 4; i++) begin
			d = 16'($urandom) & 16'h009f | 16'(i) << CTRL_RATIO;
			wr(OFS_KMUL, {8'h00, d[7:0]});
			wr(OFS_CTRL, d);
			rdchk(OFS_CTRL, d, "ctrl readback");
			rdchk(OFS_RATIO, exp_ratio(d[7:0], d[CTRL_PLL], d[CTRL_RATIO]), "ratio");
		end
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			adc_pwr <= i[0];
			dac_pwr <= i[1];
			repeat (2) @(posedge sys_clk);
			chk("osc enable", 16'(i == 0), 16'(osc_en));
			chk("audio source", 16'(i != 0), 16'(audio_clk_src));
			rdchk(OFS_STAT, {12'h0, i != 0, i == 0, 2'b00}, "stat source");
		end
		@(posedge sys_clk);
		adc_pwr <= 1'b0;
		dac_pwr <= 1'b0;
		wr(OFS_CTRL, 16'h0000);
		wr(OFS_IMASK, 16'h0001);
		for (i = 0; i < 8; i++)
			conv(2'(i % 4), i >= 4);
		auto_run(12'h040, 12'h041, 12'h0ff, 1'b1, 2'b10);
		auto_run(12'h041, 12'h041, 12'h0ff, 1'b1, 2'b11);
		auto_run(12'h080, 12'h010, 12'h080, 1'b1, 2'b00);
		auto_run(12'h081, 12'h010, 12'h080, 1'b0, 2'b00);
		auto_run(12'($urandom % 256), 12'h060, 12'h0a0, 1'b1, 2'b10);
		report_and_stop();
	end
endmodule
`default_nettype wire
